// file: hw/purc_top.sv
// Power-up reset and start-up clock sequencer.
`timescale 1ns/1ps
// Summary of operation
// - Hold chip in reset until all supplies settle, then run at 1 MHz.
// - Start-up clock is the 8 MHz RC oscillator divided by eight.
// - Generic clock generator 0 clocks the power manager from start-up.
// - Enabled synchronous system clocks are undivided and fed from generator 0.
// - All generic clocks start disabled except the watchdog generic clock.
// - All I/O pins are tri-stated after power-up until software configures.
// - On release the processor fetches SP from address zero and PC from address four.
// - Analog supply power-on monitor is always active and resets the chip.
// - Core supply brown-out monitor starts watching once start-up completes.
// - Debugger attach switches the debug data pin to its SWDIO function.
// - Crystal pins bypass the port mux; system controller selects them.
// - Regulator offers normal mode and a low-power mode for standby.
// - Bus addresses are never remapped, so reset fetch targets flash.
module purc_top (
    input  wire logic                        ref_clk_i,
    input  wire logic                        resetn_i,
    input  wire logic                        analog_supply_ok_i,
    input  wire logic                        core_supply_ok_i,
    input  wire logic                        core_supply_brownout_i,
    input  wire logic                        debugger_attach_i,
    input  wire logic                        crystal_pin_sel_i,
    input  wire logic                        standby_i,
    input  wire logic                        regulator_lp_sel_i,
    output logic                             chip_resetn_o,
    output logic                             start_clk_en_o,
    output logic                             gclk0_src_rc_o,
    output logic                             power_manager_clk_en_o,
    output logic [7:0]                       sysclk_div_o,
    output logic [purc_pkg::NGCLK-1:0]       gclk_en_o,
    output logic [purc_pkg::NPIN-1:0]        pin_oe_n_o,
    output logic [purc_pkg::SWD_SEL_W-1:0]   swdio_pin_sel_o,
    output logic [purc_pkg::SWD_SEL_W-1:0]   crystal_pin_sel_o,
    output logic                             fetch_req_o,
    output logic [31:0]                      fetch_addr_o,
    output logic                             core_bod_armed_o,
    output logic                             regulator_lp_o
);
    // =====================================================================
    // Parameters
    // =====================================================================
    localparam int unsigned SETTLE_CYC = purc_pkg::SETTLE_TIME_US * purc_pkg::START_CLK_HZ
                                         / 1_000_000;
    localparam logic [purc_pkg::SETTLE_W-1:0] SETTLE_LAST =
        purc_pkg::SETTLE_W'(SETTLE_CYC - 1);

    // =====================================================================
    // Input synchronisers
    // =====================================================================
    logic [4:0] async_in;
    logic [4:0] sync_in;
    logic       ana_ok_s;
    logic       core_ok_s;
    logic       bod_s;
    logic       dbg_s;
    logic       xsel_s;

    assign async_in = {crystal_pin_sel_i, debugger_attach_i, core_supply_brownout_i,
                       core_supply_ok_i, analog_supply_ok_i};

    purc_sync #(.W(5)) u_sync (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .async_i   (async_in),
        .sync_o    (sync_in)
    );

    assign ana_ok_s  = sync_in[0];
    assign core_ok_s = sync_in[1];
    assign bod_s     = sync_in[2];
    assign dbg_s     = sync_in[3];
    assign xsel_s    = sync_in[4];

    // =====================================================================
    // Start-up clock divider
    // =====================================================================
    // The 8 MHz RC is modelled as an enable; eight of its periods make one
    // start-up period, which is twenty reference cycles at 1 MHz.
    logic [purc_pkg::DIV_W-1:0] div_q;
    logic [purc_pkg::DIV_W-1:0] div_d;
    logic                       tick_q;
    logic                       tick_d;

    always_comb begin
        tick_d = (div_q == purc_pkg::START_DIV_LAST);
        if (tick_d) begin
            div_d = purc_pkg::DIV_RESET;
        end else begin
            div_d = div_q + 5'h01;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q  <= purc_pkg::DIV_RESET;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    // =====================================================================
    // Sequencer
    // =====================================================================
    purc_pkg::purc_state_t      st_q;
    purc_pkg::purc_state_t      st_d;
    logic [purc_pkg::SETTLE_W-1:0] cnt_q;
    logic [purc_pkg::SETTLE_W-1:0] cnt_d;
    logic                       power_good;
    logic                       fault;

    assign power_good = ana_ok_s && core_ok_s;
    // The power-on monitor is honoured in every state, RUN included.
    assign fault = !ana_ok_s || (core_bod_armed_o && bod_s);

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        if (fault) begin
            st_d  = purc_pkg::PURC_OFF;
            cnt_d = '0;
        end else begin
            case (st_q)
                purc_pkg::PURC_OFF: begin
                    if (power_good) begin
                        st_d = purc_pkg::PURC_SETTLE;
                    end
                    cnt_d = '0;
                end
                purc_pkg::PURC_SETTLE: begin
                    if (!power_good) begin
                        st_d  = purc_pkg::PURC_OFF;
                        cnt_d = '0;
                    end else if (tick_q) begin
                        if (cnt_q == SETTLE_LAST) begin
                            st_d = purc_pkg::PURC_SYNC_REL;
                        end else begin
                            cnt_d = cnt_q + 16'h0001;
                        end
                    end
                end
                purc_pkg::PURC_SYNC_REL: begin
                    if (tick_q) begin
                        st_d = purc_pkg::PURC_FETCH_SP;
                    end
                end
                purc_pkg::PURC_FETCH_SP: begin
                    if (tick_q) begin
                        st_d = purc_pkg::PURC_FETCH_PC;
                    end
                end
                purc_pkg::PURC_FETCH_PC: begin
                    if (tick_q) begin
                        st_d = purc_pkg::PURC_RUN;
                    end
                end
                purc_pkg::PURC_RUN: begin
                    st_d = purc_pkg::PURC_RUN;
                end
                default: begin
                    st_d = purc_pkg::PURC_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q  <= purc_pkg::PURC_OFF;
            cnt_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // =====================================================================
    // Registered outputs
    // =====================================================================
    logic                             released;
    logic                             chip_resetn_d;
    logic                             fetch_req_d;
    logic [31:0]                      fetch_addr_d;
    logic [purc_pkg::SWD_SEL_W-1:0]   swd_sel_d;
    logic [purc_pkg::SWD_SEL_W-1:0]   xsel_d;
    logic                             bod_arm_d;
    logic                             reg_lp_d;

    assign released = (st_d == purc_pkg::PURC_FETCH_SP) || (st_d == purc_pkg::PURC_FETCH_PC)
                      || (st_d == purc_pkg::PURC_RUN);

    always_comb begin
        chip_resetn_d = released;
        fetch_req_d   = (st_d == purc_pkg::PURC_FETCH_SP) || (st_d == purc_pkg::PURC_FETCH_PC);
        // Address map is fixed: the vector table always comes from flash at zero.
        if (st_d == purc_pkg::PURC_FETCH_PC) begin
            fetch_addr_d = purc_pkg::PC_ADDR;
        end else begin
            fetch_addr_d = purc_pkg::SP_ADDR;
        end
        swd_sel_d = dbg_s ? purc_pkg::PINMUX_SWD : purc_pkg::PINMUX_PORT;
        xsel_d    = xsel_s ? purc_pkg::PINMUX_CRYSTAL : purc_pkg::PINMUX_PORT;
        bod_arm_d = (st_d == purc_pkg::PURC_RUN);
        reg_lp_d  = (st_d == purc_pkg::PURC_RUN) && standby_i && regulator_lp_sel_i;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            chip_resetn_o          <= 1'b0;
            start_clk_en_o         <= 1'b0;
            gclk0_src_rc_o         <= 1'b1;
            power_manager_clk_en_o <= 1'b0;
            sysclk_div_o           <= purc_pkg::SYSDIV_NONE;
            gclk_en_o              <= purc_pkg::GCLK_EN_RESET;
            pin_oe_n_o             <= '1;
            swdio_pin_sel_o        <= purc_pkg::PINMUX_PORT;
            crystal_pin_sel_o      <= purc_pkg::PINMUX_PORT;
            fetch_req_o            <= 1'b0;
            fetch_addr_o           <= purc_pkg::RESET_ADDR;
            core_bod_armed_o       <= 1'b0;
            regulator_lp_o         <= 1'b0;
        end else begin
            chip_resetn_o          <= chip_resetn_d;
            start_clk_en_o         <= tick_d;
            gclk0_src_rc_o         <= 1'b1;
            power_manager_clk_en_o <= tick_d;
            sysclk_div_o           <= purc_pkg::SYSDIV_NONE;
            gclk_en_o              <= purc_pkg::GCLK_EN_RESET;
            pin_oe_n_o             <= '1;
            swdio_pin_sel_o        <= swd_sel_d;
            crystal_pin_sel_o      <= xsel_d;
            fetch_req_o            <= fetch_req_d;
            fetch_addr_o           <= fetch_addr_d;
            core_bod_armed_o       <= bod_arm_d;
            regulator_lp_o         <= reg_lp_d;
        end
    end

    // =====================================================================
    // Assertions
    // =====================================================================
    a_reset_held_low: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !ana_ok_s |=> !chip_resetn_o)
        else $error("chip reset released while analog supply is low");

    a_start_clk_rate: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        start_clk_en_o |=> !start_clk_en_o [*8] ##1 !start_clk_en_o [*8] ##1
                           !start_clk_en_o [*3] ##1 start_clk_en_o)
        else $error("start-up clock enable not one in twenty cycles");

    a_release_aligned: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(chip_resetn_o) |-> $past(tick_q))
        else $error("reset released off a start-up clock edge");

    a_first_fetch_sp: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(chip_resetn_o) |-> fetch_req_o && fetch_addr_o == 32'h0000_0000)
        else $error("first fetch is not the stack pointer at zero");

    a_wdt_only_gclk: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        gclk_en_o == 8'h04)
        else $error("generic clock enables differ from the reset set");

    a_pins_tristate: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        &pin_oe_n_o)
        else $error("an I/O pin driver is enabled");

    a_swd_follows: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(dbg_s) |=> swdio_pin_sel_o == 2'h1)
        else $error("debugger attach did not select the debug function");

    a_bod_armed_run: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        core_bod_armed_o |-> chip_resetn_o && !fetch_req_o)
        else $error("core brown-out armed before start-up completed");

    a_lp_standby: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        regulator_lp_o |-> core_bod_armed_o)
        else $error("regulator low-power mode outside run");
endmodule

// file: shared/purc_pkg.sv
// Constants and types shared by the start-up sequencer files.
package purc_pkg;
    // =====================================================================
    // Clocking
    // =====================================================================
    localparam int unsigned REF_CLK_HZ      = 20_000_000;
    localparam int unsigned RC_CLK_HZ       = 8_000_000;
    localparam int unsigned START_CLK_HZ    = 1_000_000;
    localparam int unsigned RC_DIV          = 8;
    // Reference cycles per start-up clock period.
    localparam int unsigned START_PERIOD_CYC = REF_CLK_HZ / START_CLK_HZ;
    localparam int unsigned RC_PERIOD_CYC    = REF_CLK_HZ / RC_CLK_HZ;
    localparam int unsigned DIV_W            = 5;
    localparam logic [DIV_W-1:0] START_DIV_LAST = DIV_W'(START_PERIOD_CYC - 1);
    localparam logic [DIV_W-1:0] DIV_RESET      = 5'h00;
    // =====================================================================
    // Power settle timing and other shared constants
    // =====================================================================
    localparam int unsigned SETTLE_TIME_US  = 10;
    localparam int unsigned SETTLE_W        = 16;
    localparam int unsigned NGCLK           = 8;
    localparam int unsigned WDT_GCLK_IDX    = 2;
    localparam logic [NGCLK-1:0] GCLK_EN_RESET = 8'h04;
    localparam logic [NGCLK-1:0] GCLK_EN_NONE  = 8'h00;
    localparam logic [31:0] RESET_ADDR      = 32'h0000_0000;
    localparam logic [31:0] SP_ADDR         = 32'h0000_0000;
    localparam logic [31:0] PC_ADDR         = 32'h0000_0004;
    localparam int unsigned NPIN            = 32;
    localparam int unsigned SYNC_W          = 2;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 2'h0;
    localparam logic [7:0]  SYSDIV_NONE     = 8'h00;
    localparam int unsigned SWD_SEL_W       = 2;
    localparam logic [SWD_SEL_W-1:0] PINMUX_PORT    = 2'h0;
    localparam logic [SWD_SEL_W-1:0] PINMUX_SWD     = 2'h1;
    localparam logic [SWD_SEL_W-1:0] PINMUX_CRYSTAL = 2'h2;

    typedef enum logic [2:0] {
        PURC_OFF,
        PURC_SETTLE,
        PURC_SYNC_REL,
        PURC_FETCH_SP,
        PURC_FETCH_PC,
        PURC_RUN
    } purc_state_t;
endpackage

// file: hw/purc_sync.sv
// Two flip-flop level synchroniser for asynchronous monitor inputs.
`timescale 1ns/1ps
module purc_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule

// file: test/tb_purc_top.sv
// Self-checking testbench for the power-up reset and start-up clock sequencer.
`timescale 1ns/1ps
module tb_purc_top;
    logic        ref_clk_i, resetn_i, analog_supply_ok_i, core_supply_ok_i;
    logic        core_supply_brownout_i, debugger_attach_i, crystal_pin_sel_i;
    logic        standby_i, regulator_lp_sel_i;
    logic        chip_resetn_o, start_clk_en_o, gclk0_src_rc_o, power_manager_clk_en_o;
    logic [7:0]  sysclk_div_o;
    logic [7:0]  gclk_en_o;
    logic [31:0] pin_oe_n_o;
    logic [1:0]  swdio_pin_sel_o, crystal_pin_sel_o;
    logic        fetch_req_o, core_bod_armed_o, regulator_lp_o;
    logic [31:0] fetch_addr_o;
    int          failures, n_compared, seed, cnt, since_tick, n_ticks, tick_err;
    int          sel_q[$];
    logic [31:0] val_q[$];
    int          m_sel;
    logic [31:0] m_exp, m_got;
    bit          tick_chk;

    purc_top i_purc_top (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .analog_supply_ok_i(analog_supply_ok_i), .core_supply_ok_i(core_supply_ok_i),
        .core_supply_brownout_i(core_supply_brownout_i),
        .debugger_attach_i(debugger_attach_i), .crystal_pin_sel_i(crystal_pin_sel_i),
        .standby_i(standby_i), .regulator_lp_sel_i(regulator_lp_sel_i),
        .chip_resetn_o(chip_resetn_o), .start_clk_en_o(start_clk_en_o),
        .gclk0_src_rc_o(gclk0_src_rc_o), .power_manager_clk_en_o(power_manager_clk_en_o),
        .sysclk_div_o(sysclk_div_o), .gclk_en_o(gclk_en_o), .pin_oe_n_o(pin_oe_n_o),
        .swdio_pin_sel_o(swdio_pin_sel_o), .crystal_pin_sel_o(crystal_pin_sel_o),
        .fetch_req_o(fetch_req_o), .fetch_addr_o(fetch_addr_o),
        .core_bod_armed_o(core_bod_armed_o), .regulator_lp_o(regulator_lp_o));

    // =====================================================================
    // Clock, expectation queue and watcher
    // =====================================================================
    initial ref_clk_i = 1'b0;
    always #25 ref_clk_i = ~ref_clk_i;

    function automatic logic [31:0] pick(input int s);
        case (s)
            0: pick = 32'(chip_resetn_o);
            1: pick = 32'(fetch_req_o);
            2: pick = fetch_addr_o;
            3: pick = 32'(core_bod_armed_o);
            4: pick = 32'(gclk_en_o);
            5: pick = 32'(sysclk_div_o);
            6: pick = 32'(gclk0_src_rc_o);
            7: pick = pin_oe_n_o;
            8: pick = 32'(swdio_pin_sel_o);
            9: pick = 32'(crystal_pin_sel_o);
            10: pick = 32'(regulator_lp_o);
            default: pick = 32'h1;
        endcase
    endfunction

    task automatic note(input int s, input logic [31:0] v);
        sel_q.push_back(s);
        val_q.push_back(v);
    endtask

    task automatic note_flag(input bit ok);
        note(11, 32'(ok));
    endtask

    // Notes are pushed at the falling edge and judged at the next rising edge,
    // before that edge's updates land, so both see the same output values.
    always @(posedge ref_clk_i) begin
        while (sel_q.size() > 0) begin
            m_sel = sel_q.pop_front();
            m_exp = val_q.pop_front();
            m_got = pick(m_sel);
            n_compared++;
            if (m_got !== m_exp) begin
                failures++;
                $display("mismatch at %0t: item %0d got %h expected %h", $time, m_sel, m_got,
                         m_exp);
            end
        end
    end

    // The start-up tick must repeat every 20 reference cycles and the power
    // manager enable must follow it exactly.
    always @(posedge ref_clk_i) begin
        if (!tick_chk) begin
            n_ticks = 0;
        end else begin
            if (power_manager_clk_en_o !== start_clk_en_o) tick_err++;
            if (start_clk_en_o === 1'b1 && n_ticks > 0 && since_tick != 19) tick_err++;
        end
        if (start_clk_en_o === 1'b1) begin
            n_ticks = tick_chk ? n_ticks + 1 : 0;
            since_tick = 0;
        end else begin
            since_tick++;
        end
    end

    // =====================================================================
    // Stimulus helpers
    // =====================================================================
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    task automatic wait_chip(input logic lvl, input int lim, output int n);
        n = 0;
        while (chip_resetn_o !== lvl && n < lim) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (chip_resetn_o !== lvl) begin
            failures++;
            $display("mismatch at %0t: chip reset level not reached", $time);
        end
    endtask

    task automatic check_static();
        note(4, 32'(purc_pkg::GCLK_EN_RESET));
        note(5, 32'(purc_pkg::SYSDIV_NONE));
        note(6, 32'h1);
        note(7, 32'hFFFF_FFFF);
    endtask

    task automatic conclude();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        failures++;
        conclude();
    end

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        {resetn_i, analog_supply_ok_i, core_supply_ok_i, core_supply_brownout_i} = 4'h0;
        {debugger_attach_i, crystal_pin_sel_i, standby_i, regulator_lp_sel_i} = 4'h0;
        seed = 59741;
        tick_chk = 1'b0;
        cyc(2);
        resetn_i = 1'b1;
        tick_chk = 1'b1;
        cyc(3);
        note(0, 32'h0);
        note(1, 32'h0);
        check_static();
        debugger_attach_i = 1'b1;
        cyc(4);
        note(8, 32'(purc_pkg::PINMUX_SWD));
        analog_supply_ok_i = 1'b1;
        core_supply_ok_i = 1'b1;
        core_supply_brownout_i = 1'b1;
        cyc(30);
        core_supply_brownout_i = 1'b0;
        wait_chip(1'b1, 400, cnt);
        note_flag(cnt + 30 >= 200 && cnt + 30 <= 260);
        note_flag(since_tick < 2);
        note(1, 32'h1);
        note(2, purc_pkg::SP_ADDR);
        cyc(20);
        note(2, purc_pkg::PC_ADDR);
        cyc(20);
        note(1, 32'h0);
        note(3, 32'h1);
        note(0, 32'h1);
        check_static();
        note_flag(n_ticks >= 10 && tick_err == 0);
        tick_chk = 1'b0;
        repeat (16) begin
            {debugger_attach_i, crystal_pin_sel_i, standby_i, regulator_lp_sel_i} =
                4'($random(seed));
            cyc(5);
            note(8, debugger_attach_i ? 32'(purc_pkg::PINMUX_SWD) : 32'h0);
            note(9, crystal_pin_sel_i ? 32'(purc_pkg::PINMUX_CRYSTAL) : 32'h0);
            note(10, 32'(standby_i & regulator_lp_sel_i));
        end
        {standby_i, regulator_lp_sel_i} = 2'h0;
        core_supply_brownout_i = 1'b1;
        wait_chip(1'b0, 6, cnt);
        cyc(1);
        note(3, 32'h0);
        core_supply_brownout_i = 1'b0;
        wait_chip(1'b1, 400, cnt);
        cyc(45);
        note(3, 32'h1);
        {standby_i, regulator_lp_sel_i} = 2'h3;
        analog_supply_ok_i = 1'b0;
        wait_chip(1'b0, 6, cnt);
        check_static();
        analog_supply_ok_i = 1'b1;
        cyc(100);
        analog_supply_ok_i = 1'b0;
        cyc(4);
        analog_supply_ok_i = 1'b1;
        cyc(60);
        // A core supply dip in the middle of settling must restart the count.
        core_supply_ok_i = 1'b0;
        cyc(4);
        note(0, 32'h0);
        core_supply_ok_i = 1'b1;
        wait_chip(1'b1, 400, cnt);
        note_flag(cnt >= 200);
        cyc(2);
        conclude();
    end
endmodule
